// *** rtl/pbmr_pkg.sv ***
// Shared constants and carrier types for the basic management register bank
package pbmr_pkg;

    // Timing
    localparam int unsigned CLK_PERIOD_NS       = 25;
    localparam int unsigned SOFT_RESET_TIME_NS  = 500;
    localparam int unsigned SOFT_RESET_CYCLES   = (SOFT_RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned AN_RESTART_TIME_NS  = 50;
    localparam int unsigned AN_RESTART_CYCLES   = (AN_RESTART_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Register indices
    localparam int unsigned ADDR_W              = 5;
    localparam logic [4:0]  BASIC_CONTROL       = 5'h00;
    localparam logic [4:0]  BASIC_STATUS        = 5'h01;
    localparam logic [4:0]  IDENTIFIER_HIGH     = 5'h02;
    localparam logic [4:0]  IDENTIFIER_LOW      = 5'h03;

    // Control bit positions
    localparam int unsigned CTRL_SOFT_RESET_BIT = 15;
    localparam int unsigned CTRL_LOOPBACK_BIT   = 14;
    localparam int unsigned CTRL_SPEED_BIT      = 13;
    localparam int unsigned CTRL_AN_ENABLE_BIT  = 12;
    localparam int unsigned CTRL_POWER_DOWN_BIT = 11;
    localparam int unsigned CTRL_ISOLATE_BIT    = 10;
    localparam int unsigned CTRL_AN_RESTART_BIT = 9;
    localparam int unsigned CTRL_DUPLEX_BIT     = 8;

    // Control reset values
    localparam logic        CTRL_LOOPBACK_RST   = 1'h0;
    localparam logic        CTRL_POWER_DOWN_RST = 1'h0;
    localparam logic        CTRL_ISOLATE_RST    = 1'h0;

    // Strap positions
    localparam int unsigned STRAP_DUPLEX_BIT    = 0;
    localparam int unsigned STRAP_SPEED_BIT     = 1;
    localparam int unsigned STRAP_AN_BIT        = 2;

    // Status bit positions and fixed field
    localparam int unsigned STAT_AN_DONE_BIT    = 5;
    localparam int unsigned STAT_RFAULT_BIT     = 4;
    localparam int unsigned STAT_LINK_BIT       = 2;
    localparam int unsigned STAT_JABBER_BIT     = 1;
    localparam logic [15:0] STAT_FIXED_MASK     = 16'hff09;
    localparam logic [15:0] STAT_FIXED_ONES     = 16'h7809;

    // Identifier field positions
    localparam int unsigned ID_ORG_LOW_W        = 16;
    localparam int unsigned ID_ORG_W            = 22;
    localparam int unsigned ID_MODEL_LSB        = 4;
    localparam int unsigned ID_ORG_HI_LSB       = 10;

    typedef struct packed {
        logic loopback;
        logic speed_100;
        logic an_enable;
        logic power_down;
        logic isolate;
        logic full_duplex;
    } pbmr_ctrl_t;

    typedef struct packed {
        logic link_up;
        logic remote_fault;
        logic jabber;
        logic an_complete;
    } pbmr_live_t;

    typedef struct packed {
        logic [4:0]  addr;
        logic        wr_en;
        logic        rd_en;
        logic [15:0] wr_data;
    } pbmr_req_t;

endpackage

// *** rtl/pbmr_selfclr.sv ***
// Self-clearing busy timer started by a one-cycle request
`timescale 1ns/1ps
module pbmr_selfclr #(
    parameter int unsigned CYCLES = 2
) (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic start,
    output logic      busy
);
    localparam int unsigned CW = $clog2(CYCLES + 1);

    typedef struct packed {
        logic          busy;
        logic [CW-1:0] cnt;
    } pbmr_sc_state_t;

    pbmr_sc_state_t r;
    pbmr_sc_state_t next_r;

    always_comb begin
        next_r = r;
        if (r.busy) begin
            if (r.cnt == '0) begin
                next_r.busy = 1'b0;
            end else begin
                next_r.cnt = r.cnt - CW'(1);
            end
        end else if (start) begin
            next_r.busy = 1'b1;
            next_r.cnt  = CW'(CYCLES - 1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign busy = r.busy;

    chk_busy_bound: assert property (@(posedge sys_clk) disable iff (!rst_n)
        r.busy |-> r.cnt < CW'(CYCLES))
        else $error("Busy counter out of range");
endmodule // pbmr_selfclr

// *** rtl/pbmr_latch.sv ***
// One latched status flag, latch-high or latch-low, released by a read
`timescale 1ns/1ps
module pbmr_latch #(
    parameter bit LATCH_HIGH = 1'b1
) (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic cond,
    input  wire logic rd_release,
    output logic      q
);
    typedef struct packed {
        logic q;
    } pbmr_lt_state_t;

    pbmr_lt_state_t r;
    pbmr_lt_state_t next_r;

    always_comb begin
        next_r = r;
        if (rd_release) begin
            next_r.q = cond;
        end else if (LATCH_HIGH) begin
            next_r.q = r.q | cond;
        end else begin
            next_r.q = r.q & cond;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign q = r.q;

    generate
        if (LATCH_HIGH) begin : g_high
            chk_latch_holds_high: assert property (@(posedge sys_clk) disable iff (!rst_n)
                q && !rd_release |=> q)
                else $error("Latched-high flag dropped before read");
        end else begin : g_low
            chk_latch_holds_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
                !q && !rd_release |=> !q)
                else $error("Latched-low flag rose before read");
        end
    endgenerate
endmodule // pbmr_latch

// *** rtl/pbmr_regs.sv ***
// Basic control, basic status and identifier register bank
`timescale 1ns/1ps

// What this block does
// - Writing control bit 15 starts soft reset; bit self-clears when reset completes.
// - Soft reset restores loopback, power-down and isolate defaults; straps are not resampled.
// - Control bit 14 selects loopback; resets to zero.
// - Control bit 13 forces 100 or 10 Mbps; ignored while auto-negotiation enabled.
// - Control bit 12 enables auto-negotiation, overriding forced speed and duplex.
// - Control bit 11 selects general power-down.
// - Control bit 10 isolates the MAC data interface.
// - Writing control bit 9 restarts auto-negotiation; bit self-clears.
// - Control bit 8 forces full or half duplex; ignored while auto-negotiation enabled.
// - Speed, auto-negotiation and duplex defaults come from sampled three-bit straps.
// - Status bits 14 to 11 read as ones.
// - Status bits 15, 10, 9 and 8 read as zeros.
// - Status bit 5 shows auto-negotiation complete.
// - Status bit 4 is a latched-high remote fault flag.
// - Status bits 3 and 0 read as ones.
// - Status bit 2 shows link, latched low until read.
// - Status bit 1 is a latched-high jabber flag.
// - Identifier high holds organisation identifier bits 3 through 18.
// - Identifier low holds organisation bits 19 to 24 and six-bit model.
// - Identifier low bits 3:0 hold the revision number.
// - Latched-high bit stays set until read, then follows the live condition.
// - Latched-low bit stays low until the register is read.
module pbmr_regs #(
    parameter logic [21:0] ORG_ID   = 22'h000000,  // Arbitrary value
    parameter logic [5:0]  MODEL_ID = 6'h2a,       // Arbitrary value
    parameter logic [3:0]  REV_ID   = 4'h1         // Arbitrary value
) (
    input  wire logic                 sys_clk,
    input  wire logic                 rst_n,
    input  wire logic [2:0]           mode_strap,
    input  wire pbmr_pkg::pbmr_req_t  req,
    output logic [15:0]               rd_data,
    output logic                      rd_valid,
    input  wire pbmr_pkg::pbmr_live_t live,
    input  wire logic                 an_resolved_100,
    input  wire logic                 an_resolved_full,
    output pbmr_pkg::pbmr_ctrl_t      phy_ctrl,
    output logic                      eff_speed_100,
    output logic                      eff_full_duplex,
    output logic                      soft_reset_busy,
    output logic                      an_restart_busy
);
    localparam int SR_MAX = int'(pbmr_pkg::SOFT_RESET_CYCLES) + 1;
    localparam int AR_MAX = int'(pbmr_pkg::AN_RESTART_CYCLES) + 1;

    typedef struct packed {
        pbmr_pkg::pbmr_ctrl_t ctrl;
        logic [15:0]          id_high;
        logic [15:0]          id_low;
        logic [15:0]          rd_data;
        logic                 rd_valid;
        logic                 strap_pending;
        logic                 eff_speed_100;
        logic                 eff_full_duplex;
    } pbmr_state_t;

    localparam pbmr_state_t ST_RST = '{
        ctrl: '{
            loopback:    pbmr_pkg::CTRL_LOOPBACK_RST,
            speed_100:   1'h0,
            an_enable:   1'h0,
            power_down:  pbmr_pkg::CTRL_POWER_DOWN_RST,
            isolate:     pbmr_pkg::CTRL_ISOLATE_RST,
            full_duplex: 1'h0
        },
        id_high:         ORG_ID[15:0],
        id_low:          {ORG_ID[21:16], MODEL_ID, REV_ID},
        rd_data:         16'h0000,
        rd_valid:        1'h0,
        strap_pending:   1'h1,
        eff_speed_100:   1'h0,
        eff_full_duplex: 1'h0
    };

    pbmr_state_t r;
    pbmr_state_t next_r;

    logic        wr_ctrl;
    logic        sr_start;
    logic        ar_start;
    logic        rd_status;
    logic        rfault_q;
    logic        link_q;
    logic        jabber_q;
    logic [15:0] ctrl_word;
    logic [15:0] status_word;

    assign wr_ctrl   = req.wr_en && req.addr == pbmr_pkg::BASIC_CONTROL && !soft_reset_busy;
    assign sr_start  = wr_ctrl && req.wr_data[pbmr_pkg::CTRL_SOFT_RESET_BIT];
    assign ar_start  = wr_ctrl && !req.wr_data[pbmr_pkg::CTRL_SOFT_RESET_BIT]
                       && req.wr_data[pbmr_pkg::CTRL_AN_RESTART_BIT];
    assign rd_status = req.rd_en && req.addr == pbmr_pkg::BASIC_STATUS;

    pbmr_selfclr #(
        .CYCLES (pbmr_pkg::SOFT_RESET_CYCLES)
    ) u_soft_reset (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .start   (sr_start),
        .busy    (soft_reset_busy)
    );

    pbmr_selfclr #(
        .CYCLES (pbmr_pkg::AN_RESTART_CYCLES)
    ) u_an_restart (
        .sys_clk (sys_clk),
        .rst_n   (rst_n && !soft_reset_busy),
        .start   (ar_start),
        .busy    (an_restart_busy)
    );

    pbmr_latch #(.LATCH_HIGH (1'b1)) u_rfault (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .cond       (live.remote_fault),
        .rd_release (rd_status),
        .q          (rfault_q)
    );

    pbmr_latch #(.LATCH_HIGH (1'b0)) u_link (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .cond       (live.link_up),
        .rd_release (rd_status),
        .q          (link_q)
    );

    pbmr_latch #(.LATCH_HIGH (1'b1)) u_jabber (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .cond       (live.jabber),
        .rd_release (rd_status),
        .q          (jabber_q)
    );

    // Read words
    always_comb begin
        ctrl_word = 16'h0000;
        ctrl_word[pbmr_pkg::CTRL_SOFT_RESET_BIT] = soft_reset_busy;
        ctrl_word[pbmr_pkg::CTRL_LOOPBACK_BIT]   = r.ctrl.loopback;
        ctrl_word[pbmr_pkg::CTRL_SPEED_BIT]      = r.ctrl.speed_100;
        ctrl_word[pbmr_pkg::CTRL_AN_ENABLE_BIT]  = r.ctrl.an_enable;
        ctrl_word[pbmr_pkg::CTRL_POWER_DOWN_BIT] = r.ctrl.power_down;
        ctrl_word[pbmr_pkg::CTRL_ISOLATE_BIT]    = r.ctrl.isolate;
        ctrl_word[pbmr_pkg::CTRL_AN_RESTART_BIT] = an_restart_busy;
        ctrl_word[pbmr_pkg::CTRL_DUPLEX_BIT]     = r.ctrl.full_duplex;

        status_word = pbmr_pkg::STAT_FIXED_ONES;
        status_word[pbmr_pkg::STAT_AN_DONE_BIT] = live.an_complete;
        status_word[pbmr_pkg::STAT_RFAULT_BIT]  = rfault_q;
        status_word[pbmr_pkg::STAT_LINK_BIT]    = link_q;
        status_word[pbmr_pkg::STAT_JABBER_BIT]  = jabber_q;
    end

    always_comb begin
        next_r = r;
        next_r.rd_valid = 1'b0;

        // Ordinary control write; a soft reset write carries no other settings
        if (wr_ctrl && !req.wr_data[pbmr_pkg::CTRL_SOFT_RESET_BIT]) begin
            next_r.ctrl.loopback    = req.wr_data[pbmr_pkg::CTRL_LOOPBACK_BIT];
            next_r.ctrl.speed_100   = req.wr_data[pbmr_pkg::CTRL_SPEED_BIT];
            next_r.ctrl.an_enable   = req.wr_data[pbmr_pkg::CTRL_AN_ENABLE_BIT];
            next_r.ctrl.power_down  = req.wr_data[pbmr_pkg::CTRL_POWER_DOWN_BIT];
            next_r.ctrl.isolate     = req.wr_data[pbmr_pkg::CTRL_ISOLATE_BIT];
            next_r.ctrl.full_duplex = req.wr_data[pbmr_pkg::CTRL_DUPLEX_BIT];
        end

        // Soft reset: restore fixed defaults, keep strap-derived bits
        if (sr_start || soft_reset_busy) begin
            next_r.ctrl.loopback   = pbmr_pkg::CTRL_LOOPBACK_RST;
            next_r.ctrl.power_down = pbmr_pkg::CTRL_POWER_DOWN_RST;
            next_r.ctrl.isolate    = pbmr_pkg::CTRL_ISOLATE_RST;
        end

        // Straps are taken once, in the first cycle after reset release
        if (r.strap_pending) begin
            next_r.ctrl.speed_100   = mode_strap[pbmr_pkg::STRAP_SPEED_BIT];
            next_r.ctrl.an_enable   = mode_strap[pbmr_pkg::STRAP_AN_BIT];
            next_r.ctrl.full_duplex = mode_strap[pbmr_pkg::STRAP_DUPLEX_BIT];
            next_r.strap_pending    = 1'b0;
        end

        // Identifier writes
        if (req.wr_en && req.addr == pbmr_pkg::IDENTIFIER_HIGH) begin
            next_r.id_high = req.wr_data;
        end
        if (req.wr_en && req.addr == pbmr_pkg::IDENTIFIER_LOW) begin
            next_r.id_low = req.wr_data;
        end

        // Effective mode: negotiated result overrides forced bits
        next_r.eff_speed_100   = r.ctrl.an_enable ? an_resolved_100 : r.ctrl.speed_100;
        next_r.eff_full_duplex = r.ctrl.an_enable ? an_resolved_full : r.ctrl.full_duplex;

        // Register read, unmapped indices read zero
        if (req.rd_en) begin
            next_r.rd_valid = 1'b1;
            unique case (req.addr)
                pbmr_pkg::BASIC_CONTROL:   next_r.rd_data = ctrl_word;
                pbmr_pkg::BASIC_STATUS:    next_r.rd_data = status_word;
                pbmr_pkg::IDENTIFIER_HIGH: next_r.rd_data = r.id_high;
                pbmr_pkg::IDENTIFIER_LOW:  next_r.rd_data = r.id_low;
                default:                   next_r.rd_data = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            r <= ST_RST;
        end else begin
            r <= next_r;
        end
    end

    assign rd_data         = r.rd_data;
    assign rd_valid        = r.rd_valid;
    assign phy_ctrl        = r.ctrl;
    assign eff_speed_100   = r.eff_speed_100;
    assign eff_full_duplex = r.eff_full_duplex;

    // Checks
    sequence sr_request_s;
        sr_start && !soft_reset_busy;
    endsequence

    sequence sr_complete_s;
        soft_reset_busy ##[1:SR_MAX] !soft_reset_busy;
    endsequence

    sequence ar_complete_s;
        an_restart_busy ##[1:AR_MAX] !an_restart_busy;
    endsequence

    chk_soft_reset_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
        sr_request_s |=> sr_complete_s)
        else $error("Soft reset bit did not self-clear in time");

    chk_soft_keeps_strap: assert property (@(posedge sys_clk) disable iff (!rst_n)
        sr_request_s and !r.strap_pending |=> r.ctrl.an_enable == $past(r.ctrl.an_enable)
                                  && r.ctrl.speed_100 == $past(r.ctrl.speed_100))
        else $error("Soft reset disturbed strap-derived bits");

    chk_soft_defaults: assert property (@(posedge sys_clk) disable iff (!rst_n)
        sr_request_s |=> !r.ctrl.loopback && !r.ctrl.power_down && !r.ctrl.isolate)
        else $error("Soft reset did not restore control defaults");

    chk_restart_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ar_start && !an_restart_busy |=> ar_complete_s)
        else $error("Restart bit did not self-clear in time");

    chk_strap_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
        r.strap_pending |=> r.ctrl.an_enable == $past(mode_strap[pbmr_pkg::STRAP_AN_BIT])
                         && r.ctrl.full_duplex == $past(mode_strap[pbmr_pkg::STRAP_DUPLEX_BIT]))
        else $error("Control defaults not taken from straps");

    chk_forced_speed: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !r.ctrl.an_enable |=> eff_speed_100 == $past(r.ctrl.speed_100))
        else $error("Forced speed not applied");

    chk_an_overrides: assert property (@(posedge sys_clk) disable iff (!rst_n)
        r.ctrl.an_enable |=> eff_full_duplex == $past(an_resolved_full)
                          && eff_speed_100 == $past(an_resolved_100))
        else $error("Negotiated mode did not override forced bits");

    chk_fixed_status: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rd_status |=> rd_valid && (rd_data & pbmr_pkg::STAT_FIXED_MASK) == pbmr_pkg::STAT_FIXED_ONES)
        else $error("Fixed status bits wrong");

    chk_an_done_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rd_status |=> rd_data[pbmr_pkg::STAT_AN_DONE_BIT] == $past(live.an_complete))
        else $error("Auto-negotiation complete bit wrong");

    chk_link_latched: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rd_status && !link_q |=> !rd_data[pbmr_pkg::STAT_LINK_BIT])
        else $error("Link loss not reported on read");

    chk_ctrl_write_apply: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wr_ctrl && !req.wr_data[pbmr_pkg::CTRL_SOFT_RESET_BIT] |=>
            phy_ctrl.loopback == $past(req.wr_data[pbmr_pkg::CTRL_LOOPBACK_BIT])
            && phy_ctrl.power_down == $past(req.wr_data[pbmr_pkg::CTRL_POWER_DOWN_BIT])
            && phy_ctrl.isolate == $past(req.wr_data[pbmr_pkg::CTRL_ISOLATE_BIT]))
        else $error("Control write not applied");

    chk_jabber_seen: assert property (@(posedge sys_clk) disable iff (!rst_n)
        live.jabber |=> jabber_q)
        else $error("Jabber event not latched");

    chk_rfault_seen: assert property (@(posedge sys_clk) disable iff (!rst_n)
        live.remote_fault |=> rfault_q)
        else $error("Remote fault event not latched");

    chk_link_drop_seen: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !live.link_up |=> !link_q)
        else $error("Link loss not latched");

    chk_id_high_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
        req.wr_en && req.addr == pbmr_pkg::IDENTIFIER_HIGH |=> r.id_high == $past(req.wr_data))
        else $error("Identifier write not stored");
endmodule // pbmr_regs

// *** testbench/pbmr_mac_model.sv ***
// Management controller model driving the register port
`timescale 1ns/1ps
module pbmr_mac_model (
    input  wire logic           sys_clk,
    input  wire logic [15:0]    rd_data,
    input  wire logic           rd_valid,
    output pbmr_pkg::pbmr_req_t req
);
    logic an_shadow;
    initial begin
        req = '0;
        an_shadow = 1'b1;
    end
    // One strobe cycle, then release with data inverted
    task automatic cycle(input logic [4:0] a, input logic w, input logic [15:0] d);
        @(negedge sys_clk);
        req.addr = a;
        req.wr_en = w;
        req.rd_en = !w;
        req.wr_data = d;
        @(negedge sys_clk);
        req.wr_en = 1'b0;
        req.rd_en = 1'b0;
        req.wr_data = ~d;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic [15:0] v;
        v = (a == pbmr_pkg::BASIC_CONTROL) ? {d[15:8], 8'h00} : d;
        if (a == pbmr_pkg::BASIC_CONTROL && v[11] && an_shadow) begin
            cycle(a, 1'b1, v & 16'he7ff);
        end
        if (a == pbmr_pkg::BASIC_CONTROL && !v[15]) begin
            an_shadow = v[12];
        end
        cycle(a, 1'b1, v);
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        cycle(a, 1'b0, 16'h0000);
        d = (rd_valid === 1'b1) ? rd_data : 16'hxxxx;
    endtask
    // Soft reset request carries no other bit
    task automatic soft_reset();
        cycle(pbmr_pkg::BASIC_CONTROL, 1'b1, 16'h8000);
    endtask
endmodule // pbmr_mac_model

// *** testbench/tb.sv ***
// Self-checking bench for the basic management register bank
`timescale 1ns/1ps
module tb;
    localparam logic [21:0] ORG   = 22'h2b1c3d; // Arbitrary value
    localparam logic [5:0]  MODEL = 6'h15;      // Arbitrary value
    localparam logic [3:0]  REV   = 4'h9;       // Arbitrary value
    typedef struct packed {
        logic        w;
        logic [4:0]  a;
        logic [15:0] d;
        logic [15:0] e;
    } pbmr_row_t;
    logic                 sys_clk;
    logic                 rst_n;
    logic [2:0]           mode_strap;
    pbmr_pkg::pbmr_req_t  req;
    logic [15:0]          rd_data;
    logic                 rd_valid;
    pbmr_pkg::pbmr_live_t live;
    logic                 an_resolved_100;
    logic                 an_resolved_full;
    pbmr_pkg::pbmr_ctrl_t phy_ctrl;
    logic                 eff_speed_100;
    logic                 eff_full_duplex;
    logic                 soft_reset_busy;
    logic                 an_restart_busy;
    int                   bad_count;
    int                   compares;
    logic [15:0]          got;
    int                   n;
    pbmr_row_t            rows [12];
    pbmr_regs #(.ORG_ID(ORG), .MODEL_ID(MODEL), .REV_ID(REV)) pbmr_regs_i (
        .sys_clk(sys_clk), .rst_n(rst_n), .mode_strap(mode_strap), .req(req), .rd_data(rd_data),
        .rd_valid(rd_valid), .live(live), .an_resolved_100(an_resolved_100),
        .an_resolved_full(an_resolved_full), .phy_ctrl(phy_ctrl), .eff_speed_100(eff_speed_100),
        .eff_full_duplex(eff_full_duplex), .soft_reset_busy(soft_reset_busy),
        .an_restart_busy(an_restart_busy));
    pbmr_mac_model pbmr_mac_model_i (
        .sys_clk(sys_clk), .rd_data(rd_data), .rd_valid(rd_valid), .req(req));
    always #12.5 sys_clk = ~sys_clk;
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e) begin
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
            bad_count++;
        end
    endtask
    task automatic done(input string name);
        $display("test %s finished", name);
    endtask
    task automatic waitn(input int k);
        repeat (k) @(negedge sys_clk);
    endtask
    // Length of a busy level seen at falling edges
    task automatic busy_len(input bit sel, output int c);
        c = 0;
        while (((sel ? soft_reset_busy : an_restart_busy) === 1'b1) && c < 100) begin
            c++;
            @(negedge sys_clk);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #(25 * 4000);
        bad_count++;
        report_and_stop();
    end
    initial begin
        sys_clk = 1'b0;
        rst_n = 1'b0;
        mode_strap = 3'h5;
        live = '{link_up: 1'b1, remote_fault: 1'b0, jabber: 1'b0, an_complete: 1'b1};
        an_resolved_100 = 1'b0;
        an_resolved_full = 1'b0;
        bad_count = 0;
        compares = 0;
        rows = '{'{1'b0, 5'h00, 16'h0000, 16'h1100},
                 '{1'b0, 5'h02, 16'h0000, ORG[15:0]},
                 '{1'b0, 5'h03, 16'h0000, {ORG[21:16], MODEL, REV}},
                 '{1'b1, 5'h02, 16'h5a5a, 16'h0000},
                 '{1'b0, 5'h02, 16'h0000, 16'h5a5a},
                 '{1'b1, 5'h03, 16'ha5a5, 16'h0000},
                 '{1'b0, 5'h03, 16'h0000, 16'ha5a5},
                 '{1'b1, 5'h1f, 16'hffff, 16'h0000},
                 '{1'b0, 5'h1f, 16'h0000, 16'h0000},
                 '{1'b1, 5'h00, 16'h4400, 16'h0000},
                 '{1'b0, 5'h00, 16'h0000, 16'h4400},
                 '{1'b1, 5'h00, 16'h2100, 16'h0000}};
        repeat (4) @(negedge sys_clk);
        rst_n = 1'b1;
        waitn(2);
        chk({13'h0, phy_ctrl.an_enable, phy_ctrl.speed_100, phy_ctrl.full_duplex}, 16'h0005);
        done("reset");
        foreach (rows[i]) begin
            if (rows[i].w) begin
                pbmr_mac_model_i.wr(rows[i].a, rows[i].d);
            end else begin
                pbmr_mac_model_i.rd(rows[i].a, got);
                chk(got, rows[i].e);
            end
        end
        done("table");
        waitn(2);
        chk({14'h0, eff_speed_100, eff_full_duplex}, 16'h0003);
        pbmr_mac_model_i.wr(5'h00, 16'h3100);
        waitn(2);
        chk({13'h0, phy_ctrl.an_enable, eff_speed_100, eff_full_duplex}, 16'h0004);
        done("override");
        pbmr_mac_model_i.wr(5'h00, 16'h3300);
        busy_len(1'b0, n);
        chk(16'(n), 16'(pbmr_pkg::AN_RESTART_CYCLES));
        pbmr_mac_model_i.rd(5'h00, got);
        chk(got, 16'h3100);
        done("restart");
        pbmr_mac_model_i.wr(5'h00, 16'h4d00);
        waitn(1);
        chk({13'h0, phy_ctrl.loopback, phy_ctrl.power_down, phy_ctrl.isolate}, 16'h0007);
        mode_strap = 3'h2;
        pbmr_mac_model_i.soft_reset();
        busy_len(1'b1, n);
        chk(16'(n), 16'(pbmr_pkg::SOFT_RESET_CYCLES));
        pbmr_mac_model_i.rd(5'h00, got);
        chk(got, 16'h0100);
        done("soft reset");
        pbmr_mac_model_i.rd(5'h01, got);
        pbmr_mac_model_i.rd(5'h01, got);
        chk(got, 16'h782d);
        @(negedge sys_clk);
        live.jabber = 1'b1;
        live.link_up = 1'b0;
        live.remote_fault = 1'b1;
        @(negedge sys_clk);
        live = '{link_up: 1'b1, remote_fault: 1'b0, jabber: 1'b0, an_complete: 1'b0};
        waitn(2);
        pbmr_mac_model_i.rd(5'h01, got);
        chk(got, 16'h781b);
        pbmr_mac_model_i.rd(5'h01, got);
        chk(got, 16'h780d);
        pbmr_mac_model_i.wr(5'h01, 16'h0000);
        pbmr_mac_model_i.rd(5'h01, got);
        chk(got, 16'h780d);
        done("status");
        report_and_stop();
    end
endmodule // tb
